/* File: drbcs_pkg.sv */
// Purpose: Shared constants and types for the DMA and refresh bus cycle sequencer
// Assumes: One system clock, active-low asynchronous reset
// Notes: Counts are in system clock cycles
package drbcs_pkg;
  localparam int NUM_CH = 7;
  localparam int CH_W = 3;
  localparam int NUM_CH8 = 4;
  localparam int DATA_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] REFRESH_CYCLES = 3'h3;
  localparam logic [CNT_W-1:0] REFRESH_CYCLES_PENDING = 3'h4;
  localparam logic [CNT_W-1:0] CASCADE_DELAY = 3'h2;
  localparam logic [CNT_W-1:0] TAIL8_BASE = 3'h1;
  localparam logic [7:0] BYTE_COUNT_RESET = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_CASC_PRE, ST_HOLD, ST_ADDR, ST_EARLY, ST_WAIT_INT, ST_WAIT_EXT,
    ST_END, ST_CASCADE, ST_CASC_POST, ST_TAIL, ST_REFRESH
  } drbcs_state_t;

  typedef enum logic [1:0] {KIND_DMA, KIND_CASCADE, KIND_REFRESH} drbcs_kind_t;
endpackage : drbcs_pkg

/* File: drbcs_buffer.sv */
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Synchronous push and pop on the system clock
// Notes: Full and empty are exact; a pop does not free space for the same cycle's push
`timescale 1ns/10ps
`default_nettype none
module drbcs_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr;
  logic [$clog2(DEPTH)-1:0] rd_ptr;
  logic [$clog2(DEPTH):0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != DEPTH[$clog2(DEPTH):0]);
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule : drbcs_buffer
`default_nettype wire

/* File: drbcs_sequencer.sv */
// Purpose: Sequences DMA transfer, cascade and refresh cycles on the system bus
// Assumes: Requests and refresh line are asynchronous; ready is synchronous
// Notes: Channels 0 to 3 are 8-bit, 4 to 6 are 16-bit; lowest channel wins
`timescale 1ns/10ps
`default_nettype none
// How it works
// - 8-bit service releases hold one clock later after an odd byte count.
// - Extended writes strobe one phase early; memory read and late writes later.
// - Every DMA cycle carries one internal wait state.
// - Further waits only while channel ready is low; cycle extends meanwhile.
// - 8-bit cascade adds delay cycles before hold request and after release.
// - Refresh pulse lasts three clocks without wait states.
// - Refresh pulse lasts four clocks when a DMA request is pending.
// - Channel ready low holds the refresh pulse for each added wait.
// - DMA request inputs pass a two-flop synchroniser before use.
// - Refresh line is open-drain and is also watched as an async input.
module drbcs_sequencer
  import drbcs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [NUM_CH-1:0] i_dma_request_line,
  output logic [NUM_CH-1:0] o_dma_acknowledge_line_n,
  input wire logic [NUM_CH-1:0] i_cascade_mode,
  input wire logic i_extended_write,
  input wire logic i_write_to_io,
  output logic o_cpu_hold_request,
  input wire logic i_cpu_hold_acknowledge,
  input wire logic i_channel_ready_input,
  input wire logic i_refresh_request,
  input wire logic i_refresh_in,
  output logic o_refresh_out,
  output logic o_refresh_oe,
  output logic o_refresh_seen,
  output logic o_local_io_write_strobe_n,
  output logic o_local_mem_write_strobe_n,
  output logic o_local_mem_read_strobe_n,
  input wire logic [DATA_W-1:0] i_bus_data,
  output logic o_xfer_valid,
  input wire logic i_xfer_ready,
  output logic [DATA_W-1:0] o_xfer_data
);
  function automatic logic is_8bit(input logic [CH_W-1:0] ch);
    return (ch < NUM_CH8[CH_W-1:0]);
  endfunction : is_8bit

  function automatic logic [CH_W-1:0] first_set(input logic [NUM_CH-1:0] req);
    logic [CH_W-1:0] ch;
    ch = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (req[k]) begin
        ch = k[CH_W-1:0];
      end
    end
    return ch;
  endfunction : first_set

  logic [NUM_CH-1:0] drq_meta;
  logic [NUM_CH-1:0] drq_sync;
  logic ref_meta;
  logic ref_sync;
  drbcs_state_t state;
  drbcs_state_t next_state;
  drbcs_kind_t kind;
  logic [CH_W-1:0] chan;
  logic [CNT_W-1:0] cnt;
  logic [7:0] bytes;
  logic hold_req;
  logic refresh_drive;
  logic dma_acknowledge_line_on;
  logic buf_ready;
  logic push;
  logic any_req;
  logic cur_req;

  // Request and refresh line synchronisers
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_drq_sync
      always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
          drq_meta[g] <= 1'b0;
          drq_sync[g] <= 1'b0;
        end else begin
          drq_meta[g] <= i_dma_request_line[g];
          drq_sync[g] <= drq_meta[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_meta <= 1'b1;
      ref_sync <= 1'b1;
    end else begin
      ref_meta <= i_refresh_in;
      ref_sync <= ref_meta;
    end
  end

  assign any_req = |drq_sync;
  assign cur_req = drq_sync[chan];

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (!i_cpu_hold_acknowledge && ref_sync) begin
          if (i_refresh_request) begin
            next_state = ST_HOLD;
          end else if (any_req && i_cascade_mode[first_set(drq_sync)] && is_8bit(first_set(drq_sync))) begin
            next_state = ST_CASC_PRE;
          end else if (any_req) begin
            next_state = ST_HOLD;
          end
        end
      end
      ST_CASC_PRE: begin
        if (cnt == '0) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (i_cpu_hold_acknowledge) begin
          if (kind == KIND_REFRESH) begin
            next_state = ST_REFRESH;
          end else if (kind == KIND_CASCADE) begin
            next_state = ST_CASCADE;
          end else if (buf_ready) begin
            next_state = ST_ADDR;
          end
        end
      end
      ST_ADDR: begin
        next_state = ST_EARLY;
      end
      ST_EARLY: begin
        next_state = ST_WAIT_INT;
      end
      ST_WAIT_INT: begin
        next_state = ST_WAIT_EXT;
      end
      ST_WAIT_EXT: begin
        if (i_channel_ready_input) begin
          next_state = ST_END;
        end
      end
      ST_END: begin
        if (cur_req && buf_ready) begin
          next_state = ST_ADDR;
        end else if (is_8bit(chan)) begin
          next_state = ST_TAIL;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_CASCADE: begin
        if (!cur_req) begin
          next_state = is_8bit(chan) ? ST_CASC_POST : ST_IDLE;
        end
      end
      ST_CASC_POST, ST_TAIL: begin
        if (cnt == '0) begin
          next_state = ST_IDLE;
        end
      end
      ST_REFRESH: begin
        if (cnt == '0 && i_channel_ready_input) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Request kind and channel, latched when leaving idle
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      kind <= KIND_DMA;
      chan <= '0;
    end else if (state == ST_IDLE && next_state != ST_IDLE) begin
      chan <= first_set(drq_sync);
      if (i_refresh_request) begin
        kind <= KIND_REFRESH;
      end else if (i_cascade_mode[first_set(drq_sync)]) begin
        kind <= KIND_CASCADE;
      end else begin
        kind <= KIND_DMA;
      end
    end
  end

  // Delay counter shared by cascade, tail and refresh phases
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt <= '0;
    end else if (next_state == ST_CASC_PRE && state == ST_IDLE) begin
      cnt <= CASCADE_DELAY - 1'b1;
    end else if (next_state == ST_CASC_POST && state == ST_CASCADE) begin
      cnt <= CASCADE_DELAY - 1'b1;
    end else if (next_state == ST_TAIL && state == ST_END) begin
      cnt <= TAIL8_BASE - 1'b1 + {2'h0, ~bytes[0]};
    end else if (next_state == ST_REFRESH && state == ST_HOLD) begin
      cnt <= (any_req ? REFRESH_CYCLES_PENDING : REFRESH_CYCLES) - 1'b1;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  // Bytes moved in the current service
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      bytes <= BYTE_COUNT_RESET;
    end else if (state == ST_HOLD) begin
      bytes <= BYTE_COUNT_RESET;
    end else if (state == ST_END) begin
      bytes <= bytes + 8'h01;
    end
  end

  // Bus hold, acknowledge and refresh drive, registered from next state
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_req <= 1'b0;
      dma_acknowledge_line_on <= 1'b0;
      refresh_drive <= 1'b0;
    end else begin
      hold_req <= !(next_state inside {ST_IDLE, ST_CASC_PRE});
      dma_acknowledge_line_on <= next_state inside {ST_ADDR, ST_EARLY, ST_WAIT_INT, ST_WAIT_EXT, ST_END, ST_CASCADE};
      refresh_drive <= (next_state == ST_REFRESH);
    end
  end

  assign o_cpu_hold_request = hold_req;
  assign o_dma_acknowledge_line_n = ~({{(NUM_CH-1){1'b0}}, dma_acknowledge_line_on} << chan);
  assign o_refresh_out = 1'b0;
  assign o_refresh_oe = refresh_drive;
  assign o_refresh_seen = !ref_sync && !refresh_drive;

  // Command strobes
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_local_io_write_strobe_n <= 1'b1;
      o_local_mem_write_strobe_n <= 1'b1;
      o_local_mem_read_strobe_n <= 1'b1;
    end else begin
      o_local_io_write_strobe_n <= !(i_write_to_io && ((next_state == ST_EARLY && i_extended_write) ||
        next_state inside {ST_WAIT_INT, ST_WAIT_EXT}));
      o_local_mem_write_strobe_n <= !(!i_write_to_io && ((next_state == ST_EARLY && i_extended_write) ||
        next_state inside {ST_WAIT_INT, ST_WAIT_EXT}));
      o_local_mem_read_strobe_n <= !(i_write_to_io && next_state inside {ST_WAIT_INT, ST_WAIT_EXT});
    end
  end

  // Data captured at the end of each cycle into the buffer
  assign push = (state == ST_END);

  drbcs_buffer #(
    .WIDTH(DATA_W),
    .DEPTH(BUF_DEPTH)
  ) u_buffer (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_in_valid(push),
    .o_in_ready(buf_ready),
    .i_in_data(i_bus_data),
    .o_out_valid(o_xfer_valid),
    .i_out_ready(i_xfer_ready),
    .o_out_data(o_xfer_data)
  );

  // Checking helpers
  logic [3:0] ref_len;
  logic ref_waited;
  logic ref_long;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      ref_len <= '0;
      ref_waited <= 1'b0;
      ref_long <= 1'b0;
    end else if (state == ST_HOLD) begin
      ref_len <= '0;
      ref_waited <= 1'b0;
      ref_long <= any_req;
    end else if (refresh_drive) begin
      ref_len <= ref_len + 4'h1;
      ref_waited <= ref_waited || (cnt == '0 && !i_channel_ready_input);
    end
  end

  sequence dma_cycle_entry;
    state == ST_ADDR ##1 state == ST_EARLY;
  endsequence

  sequence casc8_start;
    state == ST_IDLE && next_state == ST_CASC_PRE;
  endsequence

  internal_wait_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    dma_cycle_entry |=> state == ST_WAIT_INT ##1 state == ST_WAIT_EXT)
    else $error("DMA cycle lacks its internal wait state");

  ready_extend_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state == ST_WAIT_EXT && !i_channel_ready_input |=> state == ST_WAIT_EXT && !o_local_mem_read_strobe_n == i_write_to_io)
    else $error("DMA cycle ended while channel ready low");

  ready_end_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state == ST_WAIT_EXT && i_channel_ready_input |=> state == ST_END ##1 o_local_io_write_strobe_n)
    else $error("DMA cycle not ended at first ready high");

  early_write_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state == ST_EARLY |-> o_local_mem_read_strobe_n &&
      (o_local_io_write_strobe_n == !(i_extended_write && $past(i_write_to_io))))
    else $error("Early strobe phase wrong");

  refresh_length_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $fell(refresh_drive) && !ref_waited |-> ref_len == (ref_long ? 4'h4 : 4'h3))
    else $error("Refresh pulse length wrong");

  refresh_wait_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state == ST_REFRESH && cnt == '0 && !i_channel_ready_input |=> refresh_drive && state == ST_REFRESH)
    else $error("Refresh pulse not held during wait");

  cascade_delay_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    casc8_start |=> (!o_cpu_hold_request)[*2] ##1 o_cpu_hold_request)
    else $error("8-bit cascade hold delay wrong");

  open_drain_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_refresh_oe |-> !o_refresh_out && o_refresh_seen == 1'b0)
    else $error("Refresh line driven high");

  hold_tail_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    state == ST_END && next_state == ST_TAIL |-> ##1 o_cpu_hold_request ##1 (bytes[0] ? o_cpu_hold_request : !o_cpu_hold_request))
    else $error("8-bit hold release timing wrong");

  dma_acknowledge_line_hold_a: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $rose(dma_acknowledge_line_on) |-> o_cpu_hold_request && $past(i_cpu_hold_acknowledge))
    else $error("Acknowledge given without bus hold");
endmodule : drbcs_sequencer
`default_nettype wire

/* File: drbcs_far_side_model.sv */
// Purpose: Far side of the sequencer: CPU hold logic, ready source, refresh wire
// Assumes: One system clock, active-low asynchronous reset
// Notes: Grant delay is a parameter so the CPU can answer promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module drbcs_far_side_model #(
  parameter int ACK_DELAY = 2
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_cpu_hold_request,
  output logic o_cpu_hold_acknowledge,
  input wire logic i_stall,
  output logic o_channel_ready_input,
  input wire logic i_ext_refresh_n,
  input wire logic i_refresh_out,
  input wire logic i_refresh_oe,
  output logic o_refresh_wire
);
  logic [7:0] hold_pipe;
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_pipe <= 8'h00;
    end else begin
      hold_pipe <= {hold_pipe[6:0], i_cpu_hold_request};
    end
  end
  // CPU grants and withdraws after a fixed delay
  assign o_cpu_hold_acknowledge = hold_pipe[ACK_DELAY-1];
  // Ready low while wait states are wanted
  assign o_channel_ready_input = ~i_stall;
  // Pulled-up wire, low when either party pulls
  assign o_refresh_wire = (i_refresh_oe ? i_refresh_out : 1'b1) & i_ext_refresh_n;
endmodule : drbcs_far_side_model
`default_nettype wire

/* File: dma_refresh_bus_cycle_sequencer_tb.sv */
// Purpose: Self-checking bench for the DMA and refresh bus cycle sequencer
// Assumes: Bench plays the peripherals; far-side model plays CPU and wire
// Notes: Lengths are counted in samples taken 1 ns after rising edges
`timescale 1ns/10ps
`default_nettype none
module dma_refresh_bus_cycle_sequencer_tb;
  import drbcs_pkg::*;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  logic [NUM_CH-1:0] req = '0;
  logic [NUM_CH-1:0] casc = '0;
  logic ext_wr = 1'b1;
  logic to_io = 1'b1;
  logic stall = 1'b0;
  logic ref_req = 1'b0;
  logic ext_ref_n = 1'b1;
  logic [DATA_W-1:0] bus_data = 8'h00;
  logic xfer_ready = 1'b0;
  logic hold, hold_ack, ready, ref_out, ref_oe, ref_seen, ref_wire, iow_n, memw_n, memr_n, xfer_valid;
  logic [NUM_CH-1:0] dma_acknowledge_line_n;
  logic [DATA_W-1:0] xfer_data;
  logic [7:0] r16, f16, r8, f8;
  int n_errors = 0;
  int samples_checked = 0;
  logic [DATA_W-1:0] expq [$];

  always #2 i_clock = ~i_clock;

  drbcs_sequencer DUT (.i_clock(i_clock), .i_rstn(i_rstn), .i_dma_request_line(req),
    .o_dma_acknowledge_line_n(dma_acknowledge_line_n), .i_cascade_mode(casc), .i_extended_write(ext_wr),
    .i_write_to_io(to_io), .o_cpu_hold_request(hold), .i_cpu_hold_acknowledge(hold_ack),
    .i_channel_ready_input(ready), .i_refresh_request(ref_req), .i_refresh_in(ref_wire),
    .o_refresh_out(ref_out), .o_refresh_oe(ref_oe), .o_refresh_seen(ref_seen),
    .o_local_io_write_strobe_n(iow_n), .o_local_mem_write_strobe_n(memw_n),
    .o_local_mem_read_strobe_n(memr_n), .i_bus_data(bus_data), .o_xfer_valid(xfer_valid),
    .i_xfer_ready(xfer_ready), .o_xfer_data(xfer_data));

  drbcs_far_side_model #(.ACK_DELAY(3)) partner (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_cpu_hold_request(hold), .o_cpu_hold_acknowledge(hold_ack), .i_stall(stall),
    .o_channel_ready_input(ready), .i_ext_refresh_n(ext_ref_n), .i_refresh_out(ref_out),
    .i_refresh_oe(ref_oe), .o_refresh_wire(ref_wire));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: saw %0h want %0h", $time, seen, exp);
    end
  endtask : check

  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask : tick

  task automatic tally_and_finish();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // One DMA byte; k is the sample after which ready returns high
  task automatic dma_xfer(input int ch, input int k, input logic [7:0] len, input logic [7:0] wr_at,
                          input logic [7:0] tail, input logic [7:0] data);
    int n;
    int wr;
    int mr;
    bus_data = data;
    req[ch] = 1'b1;
    stall = (k > 0);
    n = 0;
    while (dma_acknowledge_line_n[ch] !== 1'b0 && n < 40) begin
      tick();
      n++;
    end
    req[ch] = 1'b0;
    check({1'b0, dma_acknowledge_line_n}, ~(8'h01 << ch) & 8'h7f);
    check(hold, 1'b1);
    n = 1;
    wr = 0;
    mr = 0;
    while (n < 40) begin
      tick();
      if (n == k) stall = 1'b0;
      if (dma_acknowledge_line_n[ch] !== 1'b0) break;
      if (wr == 0 && (to_io ? iow_n : memw_n) === 1'b0) wr = n;
      if (mr == 0 && memr_n === 1'b0) mr = n;
      n++;
    end
    check(8'(n), len);
    check(8'(wr), wr_at);
    if (to_io) check(8'(mr), 8'h02);
    n = 0;
    while (hold === 1'b1 && n < 10) begin
      tick();
      n++;
    end
    check(8'(n), tail);
    expq.push_back(data);
  endtask : dma_xfer

  task automatic drain(input int cnt);
    int n;
    repeat (cnt) begin
      n = 0;
      while (xfer_valid !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      check(xfer_data, expq.pop_front());
      xfer_ready = 1'b1;
      tick();
      xfer_ready = 1'b0;
    end
  endtask : drain

  task automatic ref_cycle(input int k, input logic [7:0] len);
    int n;
    ref_req = 1'b1;
    stall = (k > 0);
    n = 0;
    while (ref_oe !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    ref_req = 1'b0;
    check(ref_wire, 1'b0);
    n = 1;
    while (n < 40) begin
      tick();
      if (n == k) stall = 1'b0;
      if (ref_oe !== 1'b1) break;
      n++;
    end
    check(8'(n), len);
    check(hold, 1'b0);
  endtask : ref_cycle

  task automatic casc_run(input int ch, output logic [7:0] rise, output logic [7:0] fall);
    int n;
    casc[ch] = 1'b1;
    tick();
    req[ch] = 1'b1;
    n = 0;
    while (hold !== 1'b1 && n < 20) begin
      tick();
      n++;
    end
    rise = 8'(n);
    repeat (6) tick();
    // Master may take the bus only now
    check({dma_acknowledge_line_n[ch], iow_n, memw_n, memr_n}, 8'h07);
    req[ch] = 1'b0;
    n = 0;
    while (hold !== 1'b0 && n < 20) begin
      tick();
      n++;
    end
    fall = 8'(n);
    casc[ch] = 1'b0;
    repeat (6) tick();
  endtask : casc_run

  initial begin
    repeat (2) @(posedge i_clock);
    #1;
    i_rstn = 1'b1;
    check({hold, ref_oe, xfer_valid, ref_seen, iow_n, memw_n, memr_n, 1'b0}, 8'h0e);
    check({1'b0, dma_acknowledge_line_n}, 8'h7f);
    dma_xfer(4, 0, 8'h05, 8'h01, 8'h00, 8'h5a);
    ext_wr = 1'b0;
    to_io = 1'b0;
    dma_xfer(5, 0, 8'h05, 8'h02, 8'h00, 8'ha5);
    ext_wr = 1'b1;
    to_io = 1'b1;
    req[0] = 1'b1;
    repeat (10) tick();
    check(dma_acknowledge_line_n[0], 1'b1);
    drain(1);
    dma_xfer(0, 0, 8'h05, 8'h01, 8'h02, 8'hc3);
    drain(2);
    dma_xfer(6, 6, 8'h08, 8'h01, 8'h00, 8'h3c);
    drain(1);
    ref_cycle(0, 8'h03);
    ref_cycle(4, 8'h05);
    ref_req = 1'b1;
    tick();
    req[5] = 1'b1;
    ref_cycle(0, 8'h04);
    dma_xfer(5, 0, 8'h05, 8'h01, 8'h00, 8'h69);
    drain(1);
    casc_run(5, r16, f16);
    casc_run(1, r8, f8);
    check(r16, 8'h03);
    check(r8, r16 + 8'(CASCADE_DELAY));
    check(f8, f16 + 8'(CASCADE_DELAY));
    ext_ref_n = 1'b0;
    repeat (3) tick();
    check(ref_seen, 1'b1);
    req[4] = 1'b1;
    repeat (6) tick();
    check(hold, 1'b0);
    ext_ref_n = 1'b1;
    repeat (3) tick();
    check(ref_seen, 1'b0);
    dma_xfer(4, 0, 8'h05, 8'h01, 8'h00, 8'h96);
    drain(1);
    tally_and_finish();
  end

  initial begin
    #20000;
    n_errors++;
    tally_and_finish();
  end
endmodule : dma_refresh_bus_cycle_sequencer_tb
`default_nettype wire
